// *** din_pkg.sv ***
package din_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CFG    = 8'h00;
  localparam logic [7:0] OFF_CMD    = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_POS    = 8'h0C;
  localparam logic [7:0] OFF_CAP0   = 8'h10;
  localparam logic [7:0] OFF_CAP1   = 8'h14;

  // Configuration register field positions
  localparam int CFG_FN0_LSB = 0;   // Function of input 0, 3 bits
  localparam int CFG_POL0    = 3;   // Input 0 active low when set
  localparam int CFG_FN1_LSB = 4;   // Function of input 1, 3 bits
  localparam int CFG_POL1    = 7;   // Input 1 active low when set
  localparam int CFG_RES_LSB = 8;   // Encoder resolution, 2 bits
  localparam int CFG_ABS     = 10;  // Absolute encoder selected
  localparam int CFG_WIDTH   = 11;
  localparam logic [10:0] CFG_RESET = 11'h000;

  // Command register field positions
  localparam int CMD_TYPE_LSB = 0;  // Move type, 3 bits
  localparam int CMD_DIR      = 3;  // 1 = clockwise
  localparam int CMD_GO       = 4;  // Issue the command

  // Status register field positions
  localparam int ST_ACT_LSB  = 0;   // Active state of both inputs
  localparam int ST_LIMIT    = 2;   // Stopped on a travel limit
  localparam int ST_LIMDIR   = 3;   // Direction that hit the limit
  localparam int ST_ESTOP    = 4;   // Emergency stop input active
  localparam int ST_PEND     = 5;   // Indexer move pending
  localparam int ST_REJECT   = 6;   // Sticky: command refused
  localparam int ST_BUSY     = 7;   // Motion in progress
  localparam int ST_CAPV_LSB = 8;   // Sticky: capture valid per input

  // Input function codes
  typedef enum logic [2:0] {
    FN_GP     = 3'b000,
    FN_HOME   = 3'b001,
    FN_CWLIM  = 3'b010,
    FN_CCWLIM = 3'b011,
    FN_START  = 3'b100,
    FN_ESTOP  = 3'b101,
    FN_STOPJG = 3'b110,
    FN_RSVD   = 3'b111
  } in_fn_t;

  // Move type codes
  typedef enum logic [2:0] {
    MV_NONE  = 3'b000,
    MV_JOG   = 3'b001,
    MV_REG   = 3'b010,
    MV_INDEX = 3'b011,
    MV_HOME  = 3'b100,
    MV_OTHER = 3'b101
  } move_t;

  // Encoder resolution codes
  localparam logic [1:0] RES_1024 = 2'h0;
  localparam logic [1:0] RES_2048 = 2'h1;
  localparam logic [1:0] RES_4096 = 2'h2;

  localparam logic [31:0] POS_RESET = 32'h0000_0000;

endpackage : din_pkg

// *** din_encoder_capture.sv ***
// Overview of operation
// - Two inputs, each with a selectable function
// - Per-input polarity for normally open or closed
// - Home command seeks the assigned home sensor
// - Limit in travel direction halts motion at once
// - After limit, only opposite jogs are accepted
// - Indexer move waits for start input rising
// - Start input captures position on both edges
// - Emergency stop input halts all motion immediately
// - Driver stays enabled during emergency stop
// - No move begins while emergency stop active
// - Stop-jog rising edge decelerates jog or registration
// - Stop-jog ignored for all other move types
// - Stop-jog rising edge captures encoder position
// - Stop-jog captures only during jog or registration
// - General purpose inputs reported, no motion action
// - Captured positions are readable by the host
// - Incremental resolution 1024, 2048 or 4096 counts
// - 32-bit incremental counter, zero after reset
// - Absolute mode: 2048 per turn plus turn count
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
module din_encoder_capture
  import din_pkg::*;
(
  input  wire logic        clock,        // System clock, 50 MHz
  input  wire logic        arst_n,       // Asynchronous reset, active low
  // AHB-Lite slave
  input  wire logic        hsel,         // Slave select
  input  wire logic [7:0]  haddr,        // Byte address
  input  wire logic [1:0]  htrans,       // Transfer type
  input  wire logic        hwrite,       // Write when high
  input  wire logic [2:0]  hsize,        // Transfer size
  input  wire logic        hready,       // Bus ready in
  input  wire logic [31:0] hwdata,       // Write data
  output logic      [31:0] hrdata,       // Read data
  output logic             hreadyout,    // Slave ready
  output logic             hresp,        // Response, always OKAY
  // Field pins and encoder
  input  wire logic [1:0]  din_pin,      // Raw discrete inputs
  input  wire logic        enc_a,        // Encoder channel A
  input  wire logic        enc_b,        // Encoder channel B
  input  wire logic [20:0] abs_turns,    // Absolute turn count
  input  wire logic [10:0] abs_angle,    // Absolute angle in turn
  // Motion generator
  input  wire logic        motion_busy,  // Move in progress
  input  wire logic        motion_cw,    // Current direction clockwise
  output logic             move_start,   // Pulse: begin a move
  output logic      [2:0]  move_type,    // Type of started move
  output logic             move_cw,      // Direction of started move
  output logic             halt_now,     // Pulse: immediate stop
  output logic             decel_stop,   // Pulse: controlled stop
  output logic             home_sensor,  // Home sensor active level
  output logic             drive_enable  // Motor driver enable
);

  // Bus address phase capture
  logic        ph_wr;            // Pending write data phase
  logic [7:0]  ph_addr;          // Latched address of the last transfer
  logic        next_ph_wr;
  logic [7:0]  next_ph_addr;
  logic        acc;              // Valid address phase this cycle

  // Configuration and command state
  logic [CFG_WIDTH-1:0] cfg;     // Configuration register
  logic [CFG_WIDTH-1:0] next_cfg;
  in_fn_t      fn [2];           // Function of each input
  logic [1:0]  pol;              // Polarity of each input

  // Input synchronisers and edge detection
  logic [1:0]  sync1;            // First stage, read only by sync2
  logic [1:0]  sync2;            // Second stage
  logic [1:0]  act_q;            // Previous active level
  logic [1:0]  act;              // Active level after polarity
  logic [1:0]  rise;             // Inactive to active
  logic [1:0]  fall;             // Active to inactive

  // Encoder state
  logic [1:0]  enc_s1;           // First stage, read only by enc_s2
  logic [1:0]  enc_s2;           // Second stage
  logic [1:0]  enc_q;            // Previous decoded state
  logic [33:0] quad;             // Quadrature edge count, x4
  logic [33:0] next_quad;
  logic [31:0] pos;              // Scaled position seen by host

  // Motion control state
  logic        lim_stop;         // Stopped on a travel limit
  logic        lim_cw;           // Direction that hit the limit
  logic        pend;             // Indexer move pending
  logic        reject;           // Sticky command refusal
  logic [2:0]  cur_type;         // Type of the running move
  logic [1:0]  capv;             // Capture valid flags
  logic [31:0] cap [2];          // Captured positions
  logic        next_lim_stop;
  logic        next_lim_cw;
  logic        next_pend;
  logic        next_reject;
  logic [2:0]  next_cur_type;
  logic [1:0]  next_capv;
  logic [31:0] next_cap [2];
  logic        next_move_start;
  logic [2:0]  next_move_type;
  logic        next_move_cw;
  logic        next_halt_now;
  logic        next_decel_stop;
  logic [2:0]  pend_type;        // Indexer type is fixed
  logic        pend_cw;          // Direction of pending indexer
  logic        next_pend_cw;
  logic [31:0] next_hrdata;

  // Decoded conditions
  logic        estop_act;        // Any emergency stop input active
  logic        cw_lim_act;       // Any clockwise limit active
  logic        ccw_lim_act;      // Any counter-clockwise limit active
  logic        home_act;         // Any home sensor active
  logic        home_cfg;         // Some input assigned to home
  logic        start_rise;       // Start input rising
  logic        jogging;          // Jog or registration in progress
  logic        cmd_go;           // Command write this cycle
  logic [2:0]  cmd_type;         // Command move type
  logic        cmd_cw;           // Command direction
  logic        st_w1c;           // Status write this cycle

  assign fn[0]    = in_fn_t'(cfg[CFG_FN0_LSB +: 3]);
  assign fn[1]    = in_fn_t'(cfg[CFG_FN1_LSB +: 3]);
  assign pol      = {cfg[CFG_POL1], cfg[CFG_POL0]};
  assign pend_type = MV_INDEX;

  assign hreadyout = 1'b1;       // Zero wait states
  assign hresp     = 1'b0;       // Always OKAY
  assign acc       = hsel & htrans[1] & hready;

  // Polarity applied after sync, edges from that level
  assign act  = sync2 ^ pol;
  assign rise = act & ~act_q;
  assign fall = ~act & act_q;

  // Per-input function decode
  always_comb begin
    estop_act   = 1'b0;
    cw_lim_act  = 1'b0;
    ccw_lim_act = 1'b0;
    home_act    = 1'b0;
    home_cfg    = 1'b0;
    start_rise  = 1'b0;
    for (int i = 0; i < 2; i++) begin
      unique case (fn[i])
        FN_ESTOP:  estop_act   = estop_act | act[i];
        FN_CWLIM:  cw_lim_act  = cw_lim_act | act[i];
        FN_CCWLIM: ccw_lim_act = ccw_lim_act | act[i];
        FN_HOME: begin
          home_act = home_act | act[i];
          home_cfg = 1'b1;
        end
        FN_START:  start_rise  = start_rise | rise[i];
        default: begin
          // General purpose and reserved: report only
        end
      endcase
    end
  end

  assign jogging = motion_busy &
                   (cur_type == MV_JOG || cur_type == MV_REG);

  // Command decode from the write data phase
  assign cmd_go   = ph_wr & (ph_addr == OFF_CMD) & hwdata[CMD_GO];
  assign cmd_type = hwdata[CMD_TYPE_LSB +: 3];
  assign cmd_cw   = hwdata[CMD_DIR];
  assign st_w1c   = ph_wr & (ph_addr == OFF_STATUS);

  // Bus phase and configuration next values
  always_comb begin
    next_ph_wr   = acc & hwrite;
    next_ph_addr = acc ? haddr : ph_addr;
    next_cfg     = cfg;
    if (ph_wr && ph_addr == OFF_CFG) begin
      next_cfg = hwdata[CFG_WIDTH-1:0];
    end
  end

  // Bus phase and configuration registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ph_wr   <= 1'b0;
      ph_addr <= 8'h00;
      cfg     <= CFG_RESET;
    end else begin
      ph_wr   <= next_ph_wr;
      ph_addr <= next_ph_addr;
      cfg     <= next_cfg;
    end
  end

  // Two-stage synchronisers for pins and encoder
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync1  <= 2'h0;
      sync2  <= 2'h0;
      act_q  <= 2'h0;
      enc_s1 <= 2'h0;
      enc_s2 <= 2'h0;
      enc_q  <= 2'h0;
    end else begin
      sync1  <= din_pin;
      sync2  <= sync1;
      act_q  <= act;
      enc_s1 <= {enc_a, enc_b};
      enc_s2 <= enc_s1;
      enc_q  <= enc_s2;
    end
  end

  // Quadrature decode into the x4 edge counter
  always_comb begin
    next_quad = quad;
    if (enc_s2 != enc_q && enc_s2 != ~enc_q) begin
      if (enc_q[1] ^ enc_s2[0]) begin
        next_quad = quad + 34'h1;
      end else begin
        next_quad = quad - 34'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      quad <= {2'b00, POS_RESET};
    end else begin
      quad <= next_quad;
    end
  end

  // Position scaling by resolution or absolute word
  always_comb begin
    if (cfg[CFG_ABS]) begin
      pos = {abs_turns, abs_angle};
    end else begin
      unique case (cfg[CFG_RES_LSB +: 2])
        RES_4096: pos = quad[31:0];
        RES_2048: pos = quad[32:1];
        RES_1024: pos = quad[33:2];
        default:  pos = quad[33:2];
      endcase
    end
  end

  // Motion control, captures and status next values
  always_comb begin
    next_lim_stop   = lim_stop;
    next_lim_cw     = lim_cw;
    next_pend       = pend;
    next_pend_cw    = pend_cw;
    next_reject     = reject;
    next_cur_type   = cur_type;
    next_capv       = capv;
    next_cap[0]     = cap[0];
    next_cap[1]     = cap[1];
    next_move_start = 1'b0;
    next_move_type  = move_type;
    next_move_cw    = move_cw;
    next_halt_now   = 1'b0;
    next_decel_stop = 1'b0;

    // Software clears sticky flags, events below win
    if (st_w1c) begin
      if (hwdata[ST_REJECT]) begin
        next_reject = 1'b0;
      end
      next_capv = capv & ~hwdata[ST_CAPV_LSB +: 2];
    end

    // Emergency stop halts motion, driver untouched
    if (estop_act && motion_busy) begin
      next_halt_now = 1'b1;
    end

    // Travel limit in the current direction
    if (motion_busy && ((motion_cw && cw_lim_act) ||
                        (!motion_cw && ccw_lim_act))) begin
      next_halt_now = 1'b1;
      next_lim_stop = 1'b1;
      next_lim_cw   = motion_cw;
    end

    // Stop-jog input: only jog and registration react
    for (int i = 0; i < 2; i++) begin
      if (fn[i] == FN_STOPJG && rise[i] && jogging) begin
        next_decel_stop = 1'b1;
        next_cap[i]     = pos;
        next_capv[i]    = 1'b1;
      end
      if (fn[i] == FN_START && (rise[i] || fall[i])) begin
        next_cap[i]  = pos;
        next_capv[i] = 1'b1;
      end
    end

    // Host command
    if (cmd_go) begin
      if (estop_act) begin
        next_reject = 1'b1;
      end else if (lim_stop &&
                   !(cmd_type == MV_JOG && cmd_cw != lim_cw)) begin
        next_reject = 1'b1;
      end else if (cmd_type == MV_HOME && !home_cfg) begin
        next_reject = 1'b1;
      end else if (cmd_type == MV_INDEX) begin
        next_pend    = 1'b1;
        next_pend_cw = cmd_cw;
      end else if (cmd_type != MV_NONE) begin
        next_move_start = 1'b1;
        next_move_type  = cmd_type;
        next_move_cw    = cmd_cw;
        next_cur_type   = cmd_type;
        next_lim_stop   = 1'b0;
      end
    end else if (pend && start_rise && !estop_act && !lim_stop) begin
      next_move_start = 1'b1;
      next_move_type  = pend_type;
      next_move_cw    = pend_cw;
      next_cur_type   = pend_type;
      next_pend       = 1'b0;
    end
  end

  // Motion control, captures and status registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lim_stop   <= 1'b0;
      lim_cw     <= 1'b0;
      pend       <= 1'b0;
      pend_cw    <= 1'b0;
      reject     <= 1'b0;
      cur_type   <= MV_NONE;
      capv       <= 2'h0;
      cap[0]     <= POS_RESET;
      cap[1]     <= POS_RESET;
      move_start <= 1'b0;
      move_type  <= MV_NONE;
      move_cw    <= 1'b0;
      halt_now   <= 1'b0;
      decel_stop <= 1'b0;
    end else begin
      lim_stop   <= next_lim_stop;
      lim_cw     <= next_lim_cw;
      pend       <= next_pend;
      pend_cw    <= next_pend_cw;
      reject     <= next_reject;
      cur_type   <= next_cur_type;
      capv       <= next_capv;
      cap[0]     <= next_cap[0];
      cap[1]     <= next_cap[1];
      move_start <= next_move_start;
      move_type  <= next_move_type;
      move_cw    <= next_move_cw;
      halt_now   <= next_halt_now;
      decel_stop <= next_decel_stop;
    end
  end

  // Read data chosen in the address phase
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (acc && !hwrite) begin
      unique case (haddr)
        OFF_CFG:    next_hrdata = {21'h00_0000, cfg};
        OFF_STATUS: begin
          next_hrdata[ST_ACT_LSB +: 2]  = act;
          next_hrdata[ST_LIMIT]         = lim_stop;
          next_hrdata[ST_LIMDIR]        = lim_cw;
          next_hrdata[ST_ESTOP]         = estop_act;
          next_hrdata[ST_PEND]          = pend;
          next_hrdata[ST_REJECT]        = reject;
          next_hrdata[ST_BUSY]          = motion_busy;
          next_hrdata[ST_CAPV_LSB +: 2] = capv;
        end
        OFF_POS:    next_hrdata = pos;
        OFF_CAP0:   next_hrdata = cap[0];
        OFF_CAP1:   next_hrdata = cap[1];
        default:    next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data, home sensor and driver enable registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hrdata       <= 32'h0000_0000;
      home_sensor  <= 1'b0;
      drive_enable <= 1'b0;
    end else begin
      hrdata       <= next_hrdata;
      home_sensor  <= home_act;
      drive_enable <= 1'b1;
    end
  end

endmodule : din_encoder_capture

// *** din_encoder_capture_props.sv ***
module din_encoder_capture_props
  import din_pkg::*;
(
  input wire logic        clock,        // System clock
  input wire logic        arst_n,       // Reset, active low
  input wire logic        hsel,         // Slave select
  input wire logic [1:0]  htrans,       // Transfer type
  input wire logic        hready,       // Bus ready in
  input wire logic        hwrite,       // Write when high
  input wire logic [31:0] hrdata,       // Read data
  input wire logic        hreadyout,    // Slave ready
  input wire logic        hresp,        // Slave response
  input wire logic [1:0]  din_pin,      // Raw inputs
  input wire logic        motion_busy,  // Move in progress
  input wire logic        move_start,   // Start pulse
  input wire logic [2:0]  move_type,    // Started move type
  input wire logic        move_cw,      // Started direction
  input wire logic        halt_now,     // Immediate stop
  input wire logic        decel_stop,   // Controlled stop
  input wire logic        drive_enable  // Driver enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  logic [1:0] din_q;       // Inputs one cycle ago
  logic [3:0] quiet;       // Cycles since an input changed
  logic [3:0] next_quiet;  // Next quiet count

  // Count cycles since the last pin change, saturating
  always_comb begin
    if (din_pin != din_q) begin
      next_quiet = 4'h0;
    end else begin
      next_quiet = (quiet == 4'hF) ? quiet : quiet + 4'h1;
    end
  end

  // Register the pin history
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      din_q <= 2'h0;
      quiet <= 4'hF;
    end else begin
      din_q <= din_pin;
      quiet <= next_quiet;
    end
  end

  a_drive_held: assert property ($past(arst_n) |-> drive_enable)
    else $error("drive enable dropped");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_rdata_idle: assert property (
    !$past(hsel && htrans[1] && hready && !hwrite) |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_start_pulse: assert property (move_start |=> !move_start)
    else $error("start pulse too long");
  a_decel_pulse: assert property (decel_stop |=> !decel_stop)
    else $error("controlled stop pulse too long");
  a_type_held: assert property (
    !move_start |-> $stable(move_type) && $stable(move_cw))
    else $error("move type changed without start");
  a_decel_type: assert property (
    decel_stop |-> move_type inside {MV_JOG, MV_REG})
    else $error("controlled stop on wrong move type");
  a_halt_busy: assert property (halt_now |-> $past(motion_busy))
    else $error("halt without motion");
  a_decel_cause: assert property (decel_stop |-> quiet < 4'h8)
    else $error("controlled stop without input change");
endmodule : din_encoder_capture_props

bind din_encoder_capture din_encoder_capture_props i_props (
  .clock(clock), .arst_n(arst_n), .hsel(hsel), .htrans(htrans),
  .hready(hready), .hwrite(hwrite), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .din_pin(din_pin),
  .motion_busy(motion_busy), .move_start(move_start),
  .move_type(move_type), .move_cw(move_cw), .halt_now(halt_now),
  .decel_stop(decel_stop), .drive_enable(drive_enable));

// *** din_motion_partner.sv ***
module din_motion_partner (
  input  wire logic clock,       // System clock
  input  wire logic arst_n,      // Reset, active low
  input  wire logic move_start,  // Start pulse
  input  wire logic move_cw,     // Direction of start
  input  wire logic halt_now,    // Immediate stop
  input  wire logic decel_stop,  // Controlled stop
  input  wire logic slow,        // Late answer to starts
  output logic      motion_busy, // Moving
  output logic      motion_cw    // Direction of move
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] lag, next_lag;      // Cycles until motion
  logic [5:0] run, next_run;      // Cycles of motion left
  logic       next_busy, next_cw; // Next state

  // Ramp up, run, then stop at once or after a short ramp
  always_comb begin
    next_lag  = lag;
    next_run  = run;
    next_busy = motion_busy;
    next_cw   = motion_cw;
    if (move_start) begin                    // New move
      next_lag = slow ? 3'h4 : 3'h1;
      next_cw  = move_cw;
    end else if (lag != 3'h0) begin          // Waiting to move
      next_lag = lag - 3'h1;
      next_run = 6'h28;
      if (lag == 3'h1) next_busy = 1'b1;
    end else if (halt_now) begin             // Immediate stop
      next_busy = 1'b0;
    end else if (decel_stop && run > 6'h3) begin  // Short ramp
      next_run = 6'h3;
    end else if (run != 6'h0) begin          // Still running
      next_run = run - 6'h1;
    end else begin                           // Move complete
      next_busy = 1'b0;
    end
  end

  // Register the generator state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lag         <= 3'h0;
      run         <= 6'h0;
      motion_busy <= 1'b0;
      motion_cw   <= 1'b0;
    end else begin
      lag         <= next_lag;
      run         <= next_run;
      motion_busy <= next_busy;
      motion_cw   <= next_cw;
    end
  end
endmodule : din_motion_partner

// *** din_encoder_capture_tb_top.sv ***
module din_encoder_capture_tb_top
  import din_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, arst_n, hsel, hwrite, slow, enc_a, enc_b;
  logic [1:0]  htrans, din_pin, pol;
  logic [7:0]  haddr;
  logic [2:0]  hsize, move_type;
  logic [31:0] hwdata, hrdata, q;
  logic [20:0] abs_turns;
  logic [10:0] abs_angle;
  logic        hreadyout, hresp, motion_busy, motion_cw, move_start;
  logic        move_cw, halt_now, decel_stop, home_sensor, drive_enable;
  int          mismatches, check_count, n_halt, n_decel, ep, h;
  logic [2:0]  exp_moves[$];  // Model: moves that must start

  din_encoder_capture i_dut (.clock, .arst_n, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout,
    .hresp, .din_pin, .enc_a, .enc_b, .abs_turns, .abs_angle,
    .motion_busy, .motion_cw, .move_start, .move_type, .move_cw,
    .halt_now, .decel_stop, .home_sensor, .drive_enable);
  din_motion_partner i_partner (.clock, .arst_n, .move_start, .move_cw,
    .halt_now, .decel_stop, .slow, .motion_busy, .motion_cw);

  // Free running clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic check(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic test_done;
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // Wait for ready, taking read data at the same edge
  task automatic phase(output logic [31:0] d);
    logic r;
    for (int n = 0; n < 16; n++) begin
      @(posedge clock);
      d = hrdata;
      r = hreadyout;
      if (r === 1'b1) return;
    end
    mismatches++;
    test_done();
  endtask : phase

  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] rq);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    phase(rq);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    phase(rq);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rq;
    bus(a, 1'b1, d, rq);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
    logic [31:0] rq;
    bus(a, 1'b0, 32'h0, rq);
    check(nm, rq, e);
  endtask : rd_chk

  function automatic logic [31:0] cfgw(input logic [2:0] f0, f1,
                                       input logic [1:0] res,
                                       input logic ab);
    return {21'h0, ab, res, pol[1], f1, pol[0], f0};
  endfunction : cfgw

  // Set an input to its active or inactive level, then settle
  task automatic pin(input int i, input logic act);
    @(posedge clock);
    din_pin[i] <= act ^ pol[i];
    repeat (8) @(posedge clock);
  endtask : pin

  // Issue a move command; the model queues it if it must start
  task automatic cmd(input logic [2:0] t, input logic cw, input logic ok);
    if (ok) exp_moves.push_back(t);
    wr(OFF_CMD, {27'h0, 1'b1, cw, t});
    repeat (8) @(posedge clock);
  endtask : cmd

  // Quadrature steps, each state held three cycles
  task automatic enc_step(input int dir, input int n);
    repeat (n) begin
      ep = (ep + dir) & 3;
      @(posedge clock);
      enc_a <= ep[1];
      enc_b <= ep[1] ^ ep[0];
      repeat (2) @(posedge clock);
    end
  endtask : enc_step

  // Compare every start with the model and count stops
  always @(posedge clock) begin
    if (move_start === 1'b1) begin
      if (exp_moves.size() == 0) check("move_start", 1, 0);
      else check("move_type", {29'h0, move_type},
        exp_moves.pop_front());
    end
    if (halt_now === 1'b1) n_halt++;
    if (decel_stop === 1'b1) n_decel++;
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clock);
    mismatches++;
    test_done();
  end

  initial begin
    {arst_n, hsel, htrans, haddr, hwrite, hwdata, din_pin} = '0;
    {enc_a, enc_b, abs_turns, abs_angle, slow, pol} = '0;
    hsize = 3'h2;
    void'($urandom(2815));
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    for (int a = 0; a < 28; a += 4) rd_chk("rst", a[7:0], 32'h0);
    wr(8'h18, 32'hFFFF_FFFF);
    rd_chk("unmapped", 8'h18, 32'h0);
    pol = 2'($urandom());
    din_pin <= pol;
    abs_turns <= 21'($urandom());
    abs_angle <= 11'($urandom());
    wr(OFF_CFG, cfgw(FN_GP, FN_GP, 2'h0, 1'b0));
    rd_chk("cfg", OFF_CFG, cfgw(FN_GP, FN_GP, 2'h0, 1'b0));
    for (int v = 0; v < 4; v++) begin
      din_pin <= v[1:0] ^ pol;
      repeat (8) @(posedge clock);
      rd_chk("active", OFF_STATUS, v);
    end
    din_pin <= pol;
    enc_step(1, 16);
    for (int r = 0; r < 4; r++) begin
      wr(OFF_CFG, cfgw(FN_GP, FN_GP, r[1:0], 1'b0));
      bus(OFF_POS, 1'b0, 32'h0, q);
      check("pos", q[31] ? -q : q, 32'h10 >> (2 - r % 3));
    end
    enc_step(-1, 16);
    rd_chk("pos_back", OFF_POS, 32'h0);
    wr(OFF_CFG, cfgw(FN_START, FN_STOPJG, 2'h0, 1'b1));
    rd_chk("abs", OFF_POS, {abs_turns, abs_angle});
    cmd(MV_INDEX, 1'b1, 1'b0);
    rd_chk("pending", OFF_STATUS, 32'h20);
    exp_moves.push_back(MV_INDEX);
    pin(0, 1'b1);
    rd_chk("cap0_rise", OFF_CAP0, {abs_turns, abs_angle});
    pin(1, 1'b1);
    rd_chk("index_jogstop", OFF_STATUS, 32'h183);
    check("decel_index", n_decel, 0);
    wr(OFF_STATUS, 32'h300);
    abs_turns <= 21'($urandom());
    pin(0, 1'b0);
    rd_chk("cap0_fall", OFF_CAP0, {abs_turns, abs_angle});
    pin(1, 1'b0);
    repeat (50) @(posedge clock);
    slow <= 1'b1;
    cmd(MV_JOG, 1'b0, 1'b1);
    pin(1, 1'b1);
    check("decel_jog", n_decel, 1);
    rd_chk("cap1", OFF_CAP1, {abs_turns, abs_angle});
    pin(1, 1'b0);
    slow <= 1'b0;
    wr(OFF_STATUS, 32'h300);
    wr(OFF_CFG, cfgw(FN_ESTOP, FN_GP, 2'h0, 1'b1));
    cmd(MV_JOG, 1'b1, 1'b1);
    h = n_halt;
    pin(0, 1'b1);
    check("estop_halt", n_halt > h, 1);
    check("drive_on", drive_enable, 1);
    cmd(MV_REG, 1'b1, 1'b0);
    rd_chk("estop_st", OFF_STATUS, 32'h51);
    pin(0, 1'b0);
    wr(OFF_STATUS, 32'h40);
    wr(OFF_CFG, cfgw(FN_CWLIM, FN_GP, 2'h0, 1'b1));
    cmd(MV_JOG, 1'b1, 1'b1);
    h = n_halt;
    pin(0, 1'b1);
    check("limit_halt", n_halt > h, 1);
    rd_chk("limit_st", OFF_STATUS, 32'h0D);
    cmd(MV_JOG, 1'b1, 1'b0);
    cmd(MV_OTHER, 1'b0, 1'b0);
    cmd(MV_JOG, 1'b0, 1'b1);
    check("away_dir", move_cw, 0);
    wr(OFF_STATUS, 32'h40);
    pin(0, 1'b0);
    repeat (50) @(posedge clock);
    wr(OFF_CFG, cfgw(FN_GP, FN_HOME, 2'h0, 1'b1));
    pin(1, 1'b1);
    check("home_on", home_sensor, 1);
    cmd(MV_HOME, 1'b1, 1'b1);
    repeat (50) @(posedge clock);
    pin(1, 1'b0);
    check("home_off", home_sensor, 0);
    wr(OFF_CFG, cfgw(FN_GP, FN_GP, 2'h0, 1'b1));
    cmd(MV_HOME, 1'b1, 1'b0);
    check("moves_left", exp_moves.size(), 0);
    test_done();
  end
endmodule : din_encoder_capture_tb_top
